// *** logic/rps_output_select.sv ***
/*
 * rps_output_select: four selector registers behind AXI4-Lite, each
 * with two 6-bit fields routing one peripheral output onto pins 2..9.
 * assumes: single clock, synchronous active-high reset, peripheral
 * outputs and default port values synchronous to clock.
 */
// Behaviour
// R1 - a 6-bit selector value n routes peripheral output n onto its pin.
// R2 - bits 13-8 of the first register select the output for pin three.
// R3 - bits 5-0 of the first register select the output for pin two.
// R4 - the second register holds pin five in bits 13-8 and pin four in bits 5-0.
// R5 - the third register holds pin seven in bits 13-8 and pin six in bits 5-0.
// R6 - the fourth register holds pin nine in bits 13-8 and pin eight in bits 5-0.
// R7 - bits 15-14 and 7-6 read as zero and ignore writes.
// R8 - selector bits are read/write and clear to zero at reset.
// R9 - selector zero or an undefined number leaves the pin on its port function.
`timescale 1ns/10ps
`default_nettype none
module rps_output_select
    import rps_pkg::*;
(
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst,
    // axi4-lite write address
    input  wire logic                      s_axi_awvalid,
    output var  logic                      s_axi_awready,
    input  wire logic [31:0]               s_axi_awaddr,
    input  wire logic [2:0]                s_axi_awprot,
    // axi4-lite write data
    input  wire logic                      s_axi_wvalid,
    output var  logic                      s_axi_wready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    // axi4-lite write response
    output var  logic                      s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    output var  logic [1:0]                s_axi_bresp,
    // axi4-lite read address
    input  wire logic                      s_axi_arvalid,
    output var  logic                      s_axi_arready,
    input  wire logic [31:0]               s_axi_araddr,
    input  wire logic [2:0]                s_axi_arprot,
    // axi4-lite read data
    output var  logic                      s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output var  logic [31:0]               s_axi_rdata,
    output var  logic [1:0]                s_axi_rresp,
    // peripheral outputs and port defaults
    input  wire logic [RPS_NUM_PERIPH-1:0] periph_out,
    input  wire logic [RPS_NUM_PINS-1:0]   port_default,
    input  wire logic [RPS_NUM_PERIPH-1:0] periph_defined,
    // pins two to nine, bit 0 is pin two
    output var  logic [RPS_NUM_PINS-1:0]   remap_pin_out,
    output var  logic [RPS_NUM_PINS-1:0]   remap_pin_mapped
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [15:0] sel_reg_q [RPS_NUM_REGS];
    logic [15:0] sel_reg_d [RPS_NUM_REGS];

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    logic        aw_held_q;
    logic        w_held_q;
    logic [3:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        aw_err_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        awready_q;
    logic        wready_q;

    wire logic aw_take   = s_axi_awvalid && awready_q;
    wire logic w_take    = s_axi_wvalid && wready_q;
    wire logic aw_have   = aw_held_q || aw_take;
    wire logic w_have    = w_held_q || w_take;
    wire logic wr_fire   = aw_have && w_have && !bvalid_q;
    wire logic [3:0]  wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr[3:0];
    wire logic        wr_err  = aw_held_q ? aw_err_q : (s_axi_awaddr[31:4] != 28'h000_0000);
    wire logic [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
    wire logic [3:0]  wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    wire logic [1:0]  wr_idx  = wr_addr[3:2];
    wire logic        wr_ok   = !wr_err && (wr_addr[1:0] == 2'b00);

    // handshake state one edge ahead, so each ready is a flop
    wire logic aw_held_d = aw_have && !wr_fire;
    wire logic w_held_d  = w_have && !wr_fire;
    wire logic bvalid_d  = wr_fire || (bvalid_q && !s_axi_bready);

    // byte-lane merge, unimplemented bits forced to zero
    always_comb begin
        for (int i = 0; i < RPS_NUM_REGS; i++) begin
            sel_reg_d[i] = sel_reg_q[i];
            if (wr_fire && wr_ok && (wr_idx == 2'(i))) begin
                if (wr_strb[0]) begin
                    sel_reg_d[i][7:0] = wr_data[7:0] & RPS_IMPL_MASK[7:0]; // R7
                end
                if (wr_strb[1]) begin
                    sel_reg_d[i][15:8] = wr_data[15:8] & RPS_IMPL_MASK[15:8]; // R7
                end
            end
        end
    end

    // selector registers, cleared at reset
    always_ff @(posedge clock) begin
        for (int i = 0; i < RPS_NUM_REGS; i++) begin
            sel_reg_q[i] <= rst ? RPS_REG_RESET : sel_reg_d[i]; // R8
        end
    end

    // write handshake and response
    always_ff @(posedge clock) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 4'h0;
            aw_err_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RPS_RESP_OKAY;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
        end else begin
            awready_q <= !aw_held_d && !bvalid_d;
            wready_q  <= !w_held_d && !bvalid_d;
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? RPS_RESP_OKAY : RPS_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr[3:0];
                    aw_err_q  <= s_axi_awaddr[31:4] != 28'h000_0000;
                end
                if (w_take) begin
                    w_held_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (bvalid_q && s_axi_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        arready_q;

    wire logic       ar_take = s_axi_arvalid && arready_q;
    wire logic [1:0] rd_idx  = s_axi_araddr[3:2];
    wire logic       rd_ok   = (s_axi_araddr[31:4] == 28'h000_0000) && (s_axi_araddr[1:0] == 2'b00);
    wire logic [15:0] rd_word = sel_reg_q[rd_idx] & RPS_IMPL_MASK; // R7

    // read answer one edge ahead, for the registered arready
    wire logic       rvalid_d = ar_take || (rvalid_q && !s_axi_rready);

    // read data register, upper half reads zero
    always_ff @(posedge clock) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RPS_RESP_OKAY;
            arready_q <= 1'b0;
        end else begin
            arready_q <= !rvalid_d;
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_ok ? {16'h0000, rd_word} : 32'h0000_0000; // R8
                rresp_q  <= rd_ok ? RPS_RESP_OKAY : RPS_RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // pin routing
    // ------------------------------------------------------------
    logic [RPS_SEL_W-1:0]    pin_sel [RPS_NUM_PINS];
    logic [RPS_NUM_PINS-1:0] pin_d;
    logic [RPS_NUM_PINS-1:0] map_d;
    logic [RPS_NUM_PINS-1:0] pin_q;
    logic [RPS_NUM_PINS-1:0] map_q;

    // selector fields per pin
    assign pin_sel[0] = sel_reg_q[0][RPS_LO_LSB +: RPS_SEL_W]; // R3
    assign pin_sel[1] = sel_reg_q[0][RPS_HI_LSB +: RPS_SEL_W]; // R2
    assign pin_sel[2] = sel_reg_q[1][RPS_LO_LSB +: RPS_SEL_W]; // R4
    assign pin_sel[3] = sel_reg_q[1][RPS_HI_LSB +: RPS_SEL_W]; // R4
    assign pin_sel[4] = sel_reg_q[2][RPS_LO_LSB +: RPS_SEL_W]; // R5
    assign pin_sel[5] = sel_reg_q[2][RPS_HI_LSB +: RPS_SEL_W]; // R5
    assign pin_sel[6] = sel_reg_q[3][RPS_LO_LSB +: RPS_SEL_W]; // R6
    assign pin_sel[7] = sel_reg_q[3][RPS_HI_LSB +: RPS_SEL_W]; // R6

    // select line n, or fall back to the port
    always_comb begin
        for (int p = 0; p < RPS_NUM_PINS; p++) begin
            map_d[p] = (pin_sel[p] != RPS_SEL_NONE) && periph_defined[pin_sel[p]]; // R9
            pin_d[p] = map_d[p] ? periph_out[pin_sel[p]] : port_default[p]; // R1
        end
    end

    // registered pin drive
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_q <= 8'h00;
            map_q <= 8'h00;
        end else begin
            pin_q <= pin_d;
            map_q <= map_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready    = awready_q;
    assign s_axi_wready     = wready_q;
    assign s_axi_bvalid     = bvalid_q;
    assign s_axi_bresp      = bresp_q;
    assign s_axi_arready    = arready_q;
    assign s_axi_rvalid     = rvalid_q;
    assign s_axi_rdata      = rdata_q;
    assign s_axi_rresp      = rresp_q;
    assign remap_pin_out    = pin_q;
    assign remap_pin_mapped = map_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [RPS_SEL_W-1:0]    ref_sel [RPS_NUM_PINS];
    logic [RPS_NUM_PINS-1:0] ref_hit;
    logic [RPS_NUM_PINS-1:0] ref_line;

    // reference field slices, written out apart from the routing
    assign ref_sel[0] = sel_reg_q[0][5:0];
    assign ref_sel[1] = sel_reg_q[0][13:8];
    assign ref_sel[2] = sel_reg_q[1][5:0];
    assign ref_sel[3] = sel_reg_q[1][13:8];
    assign ref_sel[4] = sel_reg_q[2][5:0];
    assign ref_sel[5] = sel_reg_q[2][13:8];
    assign ref_sel[6] = sel_reg_q[3][5:0];
    assign ref_sel[7] = sel_reg_q[3][13:8];

    // reference line and hit per pin
    always_comb begin
        for (int p = 0; p < RPS_NUM_PINS; p++) begin
            ref_hit[p]  = (ref_sel[p] != 6'h00) && periph_defined[ref_sel[p]];
            ref_line[p] = periph_out[ref_sel[p]];
        end
    end

    // routing, field placement, register and reset checks
    chk_pin_route: assert property (@(posedge clock) disable iff (rst) // R1
        1'b1 |=> ((remap_pin_out ^ $past(ref_line)) & $past(ref_hit)) == 8'h00)
        else $error("mapped pin does not follow its selected output");
    chk_pin3_field: assert property (@(posedge clock) disable iff (rst) // R2
        1'b1 |=> ((remap_pin_out ^ $past(ref_line)) & $past(ref_hit) & 8'h02) == 8'h00)
        else $error("pin three selector misplaced");
    chk_pin2_field: assert property (@(posedge clock) disable iff (rst) // R3
        1'b1 |=> ((remap_pin_out ^ $past(ref_line)) & $past(ref_hit) & 8'h01) == 8'h00)
        else $error("pin two selector misplaced");
    chk_pin5_field: assert property (@(posedge clock) disable iff (rst) // R4
        1'b1 |=> ((remap_pin_out ^ $past(ref_line)) & $past(ref_hit) & 8'h0C) == 8'h00)
        else $error("pins five or four selector misplaced");
    chk_pin7_field: assert property (@(posedge clock) disable iff (rst) // R5
        1'b1 |=> ((remap_pin_out ^ $past(ref_line)) & $past(ref_hit) & 8'h30) == 8'h00)
        else $error("pins seven or six selector misplaced");
    chk_pin9_field: assert property (@(posedge clock) disable iff (rst) // R6
        1'b1 |=> ((remap_pin_out ^ $past(ref_line)) & $past(ref_hit) & 8'hC0) == 8'h00)
        else $error("pins nine or eight selector misplaced");
    chk_unimpl_zero: assert property (@(posedge clock) disable iff (rst) // R7
        s_axi_rvalid |-> (s_axi_rdata & 32'hFFFF_C0C0) == 32'h0000_0000)
        else $error("unimplemented bits read nonzero");
    chk_reset_clear: assert property (@(posedge clock) // R8
        $past(rst) |-> sel_reg_q[0] == 16'h0000 && remap_pin_mapped == 8'h00)
        else $error("selectors not cleared by reset");
    chk_write_lands: assert property (@(posedge clock) disable iff (rst) // R8
        wr_fire && wr_ok && wr_idx == 2'h0 && wr_strb[1:0] == 2'h3
        |=> {16'h0000, sel_reg_q[0]} == ($past(wr_data) & 32'h0000_3F3F))
        else $error("accepted write did not land in first register");
    chk_sel_hold: assert property (@(posedge clock) disable iff (rst) // R8
        !(wr_fire && wr_ok) |=> $stable(sel_reg_q[0]))
        else $error("first register changed without an accepted write");
    chk_zero_default: assert property (@(posedge clock) disable iff (rst) // R9
        1'b1 |=> remap_pin_mapped == $past(ref_hit)
            && ((remap_pin_out ^ $past(port_default)) & ~$past(ref_hit)) == 8'h00)
        else $error("unmapped pin did not keep its port function");

endmodule
`default_nettype wire

// *** logic/rps_pkg.sv ***
/*
 * rps_pkg: register map, field layout and sizes for the remappable
 * output pin select block.
 * assumes: compiled before rps_output_select; 32-bit AXI4-Lite bus.
 */
`default_nettype none
package rps_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] RPS_OFF_PINS_3_2 = 4'h0;
    localparam logic [3:0] RPS_OFF_PINS_5_4 = 4'h4;
    localparam logic [3:0] RPS_OFF_PINS_7_6 = 4'h8;
    localparam logic [3:0] RPS_OFF_PINS_9_8 = 4'hC;
    // ------------------------------------------------------------
    // field layout and reset
    // ------------------------------------------------------------
    localparam int          RPS_SEL_W      = 6;
    localparam int          RPS_LO_LSB     = 0;
    localparam int          RPS_HI_LSB     = 8;
    localparam logic [15:0] RPS_REG_RESET  = 16'h0000;
    localparam logic [15:0] RPS_IMPL_MASK  = 16'h3F3F;
    localparam int          RPS_NUM_REGS   = 4;
    localparam int          RPS_NUM_PINS   = 8;
    // number of peripheral output signals, value n selects line n
    localparam int          RPS_NUM_PERIPH = 64;
    localparam logic [5:0]  RPS_SEL_NONE   = 6'h00;
    localparam logic [1:0]  RPS_RESP_OKAY  = 2'b00;
    localparam logic [1:0]  RPS_RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// *** tb/rps_periph_model.sv ***
/* rps_periph_model: stand-in for the peripheral outputs and port defaults.
   assumes: bench clock and reset; outputs invert each cycle so stale pins show. */
`timescale 1ns/10ps
`default_nettype none
module rps_periph_model
    import rps_pkg::*;
(
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst,
    // toward the pin selector
    output var  logic [RPS_NUM_PERIPH-1:0] periph_out,
    output var  logic [RPS_NUM_PINS-1:0]   port_default,
    output var  logic [RPS_NUM_PERIPH-1:0] periph_defined
);
    // outputs 0 and 63 do not exist
    assign periph_defined = 64'h7FFF_FFFF_FFFF_FFFE;
    // invert every cycle so a stale selection is seen
    always_ff @(posedge clock) begin
        if (rst) begin
            periph_out   <= 64'hC3A5_0F96_5A3C_E187;
            port_default <= 8'h5A;
        end else begin
            periph_out   <= ~periph_out;
            port_default <= ~port_default;
        end
    end
endmodule
`default_nettype wire

// *** tb/remappable_output_pin_select_test.sv ***
/* remappable_output_pin_select_test: register and pin routing scenarios.
   assumes: rps_pkg and rps_output_select compiled first. */
`timescale 1ns/10ps
`default_nettype none
module remappable_output_pin_select_test;
    import rps_pkg::*;
    logic        clock, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [63:0] periph_out, periph_defined;
    logic [7:0]  port_default, pin_out, pin_mapped;
    logic [5:0]  sel [8];
    int          n_fail, n_compared;
    rps_output_select dut (.clock(clock), .rst(rst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .periph_out(periph_out), .port_default(port_default),
        .periph_defined(periph_defined), .remap_pin_out(pin_out), .remap_pin_mapped(pin_mapped));
    rps_periph_model far (.clock(clock), .rst(rst), .periph_out(periph_out),
        .port_default(port_default), .periph_defined(periph_defined));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // write one word, hold each channel until taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        @(posedge clock);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
        forever begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        chk("bresp", {30'h0, exp_resp}, {30'h0, bresp});
        bready <= 1'b0;
    endtask
    // read one word and compare data and response
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        @(posedge clock);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        chk("rdata", exp, rdata);
        chk("rresp", {30'h0, exp_resp}, {30'h0, rresp});
        rready <= 1'b0;
    endtask
    // pins reflect last cycle's inputs, which are the inverse of now
    task automatic chk_pins();
        logic [7:0] eo, em;
        @(negedge clock);
        for (int p = 0; p < 8; p++) begin
            em[p] = (sel[p] != 6'h00) && periph_defined[sel[p]];
            eo[p] = em[p] ? ~periph_out[sel[p]] : ~port_default[p];
        end
        chk("pin_out", {24'h0, eo}, {24'h0, pin_out});
        chk("pin_mapped", {24'h0, em}, {24'h0, pin_mapped});
    endtask
    task automatic set_reg(input int k, input logic [5:0] hi, input logic [5:0] lo);
        sel[2*k] = lo;
        sel[2*k+1] = hi;
        wr(32'(4*k), {18'h0, hi, 2'b00, lo}, RPS_RESP_OKAY);
        rd(32'(4*k), {18'h0, hi, 2'b00, lo}, RPS_RESP_OKAY);
        chk_pins();
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int k = 0; k < 4; k++) rd(32'(4*k), 32'h0000_0000, RPS_RESP_OKAY);
        chk_pins();
    endtask
    task automatic t_mask();
        for (int k = 0; k < 4; k++) begin
            wr(32'(4*k), 32'hFFFF_FFFF, RPS_RESP_OKAY);
            rd(32'(4*k), 32'h0000_3F3F, RPS_RESP_OKAY);
            wr(32'(4*k), 32'h0000_0000, RPS_RESP_OKAY);
        end
    endtask
    task automatic t_route();
        for (int k = 0; k < 4; k++) set_reg(k, 6'(k*14+12), 6'(k*14+5));
        set_reg(0, 6'h3F, 6'h00);
        set_reg(3, 6'h01, 6'h3E);
    endtask
    task automatic t_bad();
        wr(32'h0000_0010, 32'h0000_0101, RPS_RESP_SLVERR);
        wr(32'h0000_0002, 32'h0000_0101, RPS_RESP_SLVERR);
        rd(32'h0000_0010, 32'h0000_0000, RPS_RESP_SLVERR);
        rd(32'h0000_0000, 32'h0000_3F00, RPS_RESP_OKAY);
    endtask
    // reset in mid-run clears selectors and returns pins to the port
    task automatic t_rerst();
        set_reg(1, 6'h2A, 6'h15);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int p = 0; p < 8; p++) sel[p] = 6'h00;
        rd(32'h0000_0004, 32'h0000_0000, RPS_RESP_OKAY);
        chk_pins();
    endtask
    task automatic tally_and_finish();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ------------------------------------------------------------
    // clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #50000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        n_fail = 0; n_compared = 0; rst = 1'b1;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0;
        for (int p = 0; p < 8; p++) sel[p] = 6'h00;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_mask();
        t_route();
        t_bad();
        t_rerst();
        tally_and_finish();
    end
endmodule
`default_nettype wire
